// [hdl/mio_consts.vh]
// register offsets, reset values and codes of the multiplexed io bank
`ifndef MIO_CONSTS_VH
`define MIO_CONSTS_VH
`define MIO_PINS 117
`define MIO_PORTS 8
`define MIO_LINES 24
`define MIO_WAKE_LINES 16
`define MIO_FILT_FIRST 16
`define MIO_EXTERNAL_IRQ_LINE_PIN0 82
`define MIO_REG_FUNC 2'h0
`define MIO_REG_DATA 2'h1
`define MIO_REG_PUD 2'h2
`define MIO_ADR_MISC 8'h80
`define MIO_ADR_TRIG0 8'h88
`define MIO_ADR_TRIG1 8'h8C
`define MIO_ADR_TRIG2 8'h90
`define MIO_ADR_FILT 8'h94
`define MIO_ADR_MASK 8'h98
`define MIO_ADR_PEND 8'h9C
`define MIO_FUNC_A_RST 32'h007FFFFF
`define MIO_RST_ZERO 32'h00000000
`define MIO_MASK_RST 24'hFFFFFF
`define MIO_F_IN 2'h0
`define MIO_F_OUT 2'h1
`define MIO_F_ALT1 2'h2
`define MIO_F_ALT2 2'h3
`define MIO_TRG_LOW 3'h0
`define MIO_TRG_HIGH 3'h1
`define MIO_TRG_FALL 2'h1
`define MIO_TRG_RISE 2'h2
`define MIO_TRG_BOTH 2'h3
`define MIO_RESP_OKAY 2'h0
`define MIO_RESP_SLVERR 2'h2
`endif

// [hdl/mio_top.v]
// multiplexed io port bank with external interrupt lines and axi4-lite
`timescale 1ns/1ps
`include "mio_consts.vh"

////////////////////////////////////////////////////////////////////////////
module mio_top (
  input wire clk_sys_in,
  input wire rst_b_in,
  input wire [7:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output reg s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output reg s_axi_wready_out,
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [7:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output reg s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire [116:0] pin_in,
  output reg [116:0] pin_out,
  output reg [116:0] pin_oe_out,
  output reg [93:0] pullup_en_out,
  input wire [116:0] alt1_drive_in,
  input wire [116:0] alt1_oe_in,
  input wire [116:0] alt2_drive_in,
  input wire [116:0] alt2_oe_in,
  output reg [116:0] pin_sync_out,
  output reg [31:0] misc_ctrl_out,
  input wire power_off_in,
  output reg wake_out,
  output reg irq_out,
  output reg ext_irq_group_low_pending_out,
  output reg ext_irq_group_high_pending_out
);

  function integer pbase;
    input integer p;
    begin
      case (p)
        0: pbase = 0;
        1: pbase = 23;
        2: pbase = 34;
        3: pbase = 50;
        4: pbase = 66;
        5: pbase = 82;
        6: pbase = 90;
        7: pbase = 106;
        default: pbase = 117;
      endcase
    end
  endfunction

  function integer pnum;
    input integer i;
    integer k;
    begin
      pnum = 0;
      for (k = 1; k < 8; k = k + 1)
        if (i >= pbase(k))
          pnum = k;
    end
  endfunction

  function [31:0] pmask;
    input integer p;
    begin
      pmask = (32'h00000001 << (pbase(p + 1) - pbase(p))) - 32'h00000001;
    end
  endfunction

  function [31:0] fmask;
    input integer p;
    begin
      if (p == 3'h0)
        fmask = pmask(p);
      else if (pbase(p + 1) - pbase(p) >= 16)
        fmask = 32'hFFFFFFFF;
      else
        fmask = (32'h00000001 << (2 * (pbase(p + 1) - pbase(p))))
          - 32'h00000001;
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          merge[8 * k +: 8] = nw[8 * k +: 8];
    end
  endfunction

  reg [31:0] func_r [0:7];
  reg [31:0] data_r [0:7];
  reg [31:0] pud_r [0:7];
  reg [31:0] trig_r [0:2];
  reg [15:0] filt_r;
  reg [23:0] mask_r;
  reg [23:0] pend_r;
  reg [116:0] sync1;
  reg [7:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;
  wire [233:0] pin_f;
  wire [116:0] next_out;
  wire [116:0] next_oe;
  wire [116:0] rd_bit;
  wire [93:0] next_pu;
  wire [23:0] hit;
  reg [31:0] next_rdata;
  reg next_rerr;
  reg wr_err;
  reg [23:0] pend_clr;
  wire [116:0] rd_shift;
  wire [31:0] clr_m;
  wire [31:0] filt_m;
  wire [31:0] mask_m;
  integer n;

  // full-word merges, cut to register width where they are used
  assign rd_shift = rd_bit >> pbase(s_axi_araddr_in[6:4]);
  assign clr_m = merge(`MIO_RST_ZERO, w_data, w_strb);
  assign filt_m = merge({16'h0000, filt_r}, w_data, w_strb);
  assign mask_m = merge({8'h00, mask_r}, w_data, w_strb);

  ////////////////////////////////////////////////////////////////////////////
  // per-pin function mux
  genvar i;
  generate
    for (i = 0; i < 117; i = i + 1)
    begin : g_pin
      localparam P = pnum(i);
      localparam B = i - pbase(P);
      if (P == 0)
      begin : g_a
        // first port: bit 0 plain output, 1 alternate
        assign pin_f[2 * i +: 2] = func_r[0][B] ? `MIO_F_ALT1 : `MIO_F_OUT;
      end
      else
      begin : g_io
        assign pin_f[2 * i +: 2] = func_r[P][2 * B +: 2];
        assign next_pu[i - 23] = ~pud_r[P][B];
      end
      assign next_out[i] = (pin_f[2 * i +: 2] == `MIO_F_OUT) ? data_r[P][B] :
        (pin_f[2 * i +: 2] == `MIO_F_ALT1) ? alt1_drive_in[i] :
        (pin_f[2 * i +: 2] == `MIO_F_ALT2) ? alt2_drive_in[i] : 1'b0;
      assign next_oe[i] = (P == 0) || (pin_f[2 * i +: 2] == `MIO_F_OUT) ||
        (pin_f[2 * i +: 2] == `MIO_F_ALT1 && alt1_oe_in[i]) ||
        (pin_f[2 * i +: 2] == `MIO_F_ALT2 && alt2_oe_in[i]);
      assign rd_bit[i] = (pin_f[2 * i +: 2] == `MIO_F_IN) ? pin_sync_out[i] :
        (pin_f[2 * i +: 2] == `MIO_F_OUT) ? data_r[P][B] : 1'b0;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // external interrupt lines: filter and trigger detection
  generate
    for (i = 0; i < 24; i = i + 1)
    begin : g_line
      localparam Q = `MIO_EXTERNAL_IRQ_LINE_PIN0 + i;
      reg lvl;
      reg lvl_d;
      reg [7:0] cnt;
      wire [2:0] cfg = trig_r[i / 8][(i % 8) * 4 +: 3];
      wire sel = pin_f[2 * Q +: 2] == `MIO_F_ALT1;
      wire flt_on = (i >= `MIO_FILT_FIRST) && filt_r[i % 8];
      always @(posedge clk_sys_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
        begin
          lvl <= 1'b1;
          lvl_d <= 1'b1;
          cnt <= 8'h00;
        end
        else
        begin
          lvl_d <= lvl;
          if (!flt_on || pin_sync_out[Q] == lvl)
          begin
            cnt <= 8'h00;
            lvl <= pin_sync_out[Q];
          end
          else if (cnt == filt_r[15:8])
          begin
            cnt <= 8'h00;
            lvl <= pin_sync_out[Q];
          end
          else
            cnt <= cnt + 8'h01;
        end
      end
      assign hit[i] = sel && (
        (cfg == `MIO_TRG_LOW && !lvl) ||
        (cfg == `MIO_TRG_HIGH && lvl) ||
        (cfg[2:1] == `MIO_TRG_FALL && lvl_d && !lvl) ||
        (cfg[2:1] == `MIO_TRG_RISE && !lvl_d && lvl) ||
        (cfg[2:1] == `MIO_TRG_BOTH && lvl_d != lvl));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register read decode
  always @*
  begin
    next_rdata = `MIO_RST_ZERO;
    next_rerr = 1'b0;
    if (!s_axi_araddr_in[7])
    begin
      case (s_axi_araddr_in[3:2])
        `MIO_REG_FUNC: next_rdata = func_r[s_axi_araddr_in[6:4]];
        `MIO_REG_DATA: next_rdata = rd_shift[31:0] &
          pmask(s_axi_araddr_in[6:4]);
        `MIO_REG_PUD:
        begin
          next_rdata = pud_r[s_axi_araddr_in[6:4]];
          next_rerr = s_axi_araddr_in[6:4] == 3'h0;
        end
        default: next_rerr = 1'b1;
      endcase
    end
    else
    begin
      case (s_axi_araddr_in)
        `MIO_ADR_MISC: next_rdata = misc_ctrl_out;
        `MIO_ADR_TRIG0: next_rdata = trig_r[0];
        `MIO_ADR_TRIG1: next_rdata = trig_r[1];
        `MIO_ADR_TRIG2: next_rdata = trig_r[2];
        `MIO_ADR_FILT: next_rdata = {16'h0000, filt_r};
        `MIO_ADR_MASK: next_rdata = {8'h00, mask_r};
        `MIO_ADR_PEND: next_rdata = {8'h00, pend_r};
        default: next_rerr = 1'b1;
      endcase
    end
  end

  always @*
  begin
    wr_err = 1'b0;
    if (!aw_addr[7])
      wr_err = (aw_addr[3:2] == 2'h3) ||
        (aw_addr[3:2] == `MIO_REG_PUD && aw_addr[6:4] == 3'h0);
    else if (aw_addr != `MIO_ADR_MISC && aw_addr != `MIO_ADR_TRIG0 &&
      aw_addr != `MIO_ADR_TRIG1 && aw_addr != `MIO_ADR_TRIG2 &&
      aw_addr != `MIO_ADR_FILT && aw_addr != `MIO_ADR_MASK &&
      aw_addr != `MIO_ADR_PEND)
      wr_err = 1'b1;
    pend_clr = 24'h000000;
    if (aw_held && w_held && !s_axi_bvalid_out && aw_addr == `MIO_ADR_PEND)
      pend_clr = clr_m[23:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave, registers and pin outputs; reset only by rst_b_in
  always @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (n = 0; n < 8; n = n + 1)
      begin
        func_r[n] <= (n == 0) ? `MIO_FUNC_A_RST : `MIO_RST_ZERO;
        data_r[n] <= `MIO_RST_ZERO;
        pud_r[n] <= `MIO_RST_ZERO;
      end
      for (n = 0; n < 3; n = n + 1)
        trig_r[n] <= `MIO_RST_ZERO;
      filt_r <= 16'h0000;
      mask_r <= `MIO_MASK_RST;
      pend_r <= 24'h000000;
      misc_ctrl_out <= `MIO_RST_ZERO;
      sync1 <= {117{1'b0}};
      pin_sync_out <= {117{1'b0}};
      pin_out <= {117{1'b0}};
      pin_oe_out <= {117{1'b0}};
      pullup_en_out <= {94{1'b0}};
      wake_out <= 1'b0;
      irq_out <= 1'b0;
      ext_irq_group_low_pending_out <= 1'b0;
      ext_irq_group_high_pending_out <= 1'b0;
      aw_addr <= 8'h00;
      aw_held <= 1'b0;
      w_data <= `MIO_RST_ZERO;
      w_strb <= 4'h0;
      w_held <= 1'b0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `MIO_RESP_OKAY;
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rresp_out <= `MIO_RESP_OKAY;
      s_axi_rdata_out <= `MIO_RST_ZERO;
    end
    else
    begin
      sync1 <= pin_in;
      pin_sync_out <= sync1;
      pin_out <= next_out;
      pin_oe_out <= next_oe;
      pullup_en_out <= next_pu;
      // set wins over a clearing write in the same cycle
      pend_r <= (pend_r & ~pend_clr) | hit;
      irq_out <= |(pend_r & ~mask_r);
      wake_out <= power_off_in && |hit[`MIO_WAKE_LINES - 1:0];
      ext_irq_group_low_pending_out <= |(pend_r[7:4] & ~mask_r[7:4]);
      ext_irq_group_high_pending_out <= |(pend_r[23:8] & ~mask_r[23:8]);
      s_axi_awready_out <= !aw_held && !s_axi_awready_out && s_axi_awvalid_in;
      s_axi_wready_out <= !w_held && !s_axi_wready_out && s_axi_wvalid_in;
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (aw_held && w_held && !s_axi_bvalid_out)
      begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_err ? `MIO_RESP_SLVERR : `MIO_RESP_OKAY;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        if (!wr_err && !aw_addr[7])
        begin
          case (aw_addr[3:2])
            `MIO_REG_FUNC: func_r[aw_addr[6:4]] <= merge(func_r[aw_addr[6:4]],
              w_data, w_strb) & fmask(aw_addr[6:4]);
            `MIO_REG_DATA: data_r[aw_addr[6:4]] <= merge(data_r[aw_addr[6:4]],
              w_data, w_strb) & pmask(aw_addr[6:4]);
            default: pud_r[aw_addr[6:4]] <= merge(pud_r[aw_addr[6:4]],
              w_data, w_strb) & pmask(aw_addr[6:4]);
          endcase
        end
        else if (!wr_err)
        begin
          case (aw_addr)
            `MIO_ADR_MISC: misc_ctrl_out <= merge(misc_ctrl_out, w_data,
              w_strb);
            `MIO_ADR_TRIG0: trig_r[0] <= merge(trig_r[0], w_data, w_strb);
            `MIO_ADR_TRIG1: trig_r[1] <= merge(trig_r[1], w_data, w_strb);
            `MIO_ADR_TRIG2: trig_r[2] <= merge(trig_r[2], w_data, w_strb);
            `MIO_ADR_FILT: filt_r <= filt_m[15:0];
            `MIO_ADR_MASK: mask_r <= mask_m[23:0];
            default: ;
          endcase
        end
      end
      else if (s_axi_bvalid_out && s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
      s_axi_arready_out <= !s_axi_arready_out && !s_axi_rvalid_out &&
        s_axi_arvalid_in;
      if (s_axi_arvalid_in && s_axi_arready_out)
      begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= next_rdata;
        s_axi_rresp_out <= next_rerr ? `MIO_RESP_SLVERR : `MIO_RESP_OKAY;
      end
      else if (s_axi_rvalid_out && s_axi_rready_in)
        s_axi_rvalid_out <= 1'b0;
    end
  end

endmodule // mio_top

// [bench/mio_monitor.sv]
// assertions on the io bank bus, pins and wake output
`timescale 1ns/1ps
module mio_monitor (
  input wire clk_sys_in,
  input wire rst_b_in,
  input wire s_axi_awvalid_in,
  input wire s_axi_awready_out,
  input wire [1:0] s_axi_bresp_out,
  input wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire s_axi_arready_out,
  input wire [31:0] s_axi_rdata_out,
  input wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire [116:0] pin_in,
  input wire [116:0] pin_oe_out,
  input wire [116:0] pin_sync_out,
  input wire power_off_in,
  input wire wake_out
);
  reg [1:0] up;
  // cycles since reset release, saturating
  always @(posedge clk_sys_in or negedge rst_b_in)
    if (!rst_b_in)
      up <= 2'h0;
    else if (up != 2'h3)
      up <= up + 2'h1;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  property p_aw;
    s_axi_awready_out |-> $past(s_axi_awvalid_in) ##1 !s_axi_awready_out;
  endproperty
  a_aw: assert property (p_aw) else $error("stray awready");
  property p_bhold;
    s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rhold;
    s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_rhold: assert property (p_rhold) else $error("rvalid dropped");
  property p_rblk;
    s_axi_rvalid_out |-> !s_axi_arready_out;
  endproperty
  a_rblk: assert property (p_rblk) else $error("arready during rvalid");
  property p_bresp;
    s_axi_bvalid_out |-> !s_axi_bresp_out[0];
  endproperty
  a_bresp: assert property (p_bresp) else $error("bad bresp");
  property p_porta;
    up == 2'h3 |-> &pin_oe_out[22:0];
  endproperty
  a_porta: assert property (p_porta) else $error("port a undriven");
  property p_sync;
    up == 2'h3 |-> pin_sync_out == $past(pin_in, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("sync latency");
  property p_wake;
    wake_out |-> $past(power_off_in);
  endproperty
  a_wake: assert property (p_wake) else $error("wake while on");
  c_wr: cover property (s_axi_bvalid_out && s_axi_bready_in);
  c_rd: cover property (s_axi_rvalid_out && s_axi_rready_in);
  c_wake: cover property (wake_out);
endmodule // mio_monitor
bind mio_top mio_monitor i_mon (.clk_sys_in, .rst_b_in, .s_axi_awvalid_in,
  .s_axi_awready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
  .s_axi_bready_in, .s_axi_arready_out, .s_axi_rdata_out,
  .s_axi_rvalid_out, .s_axi_rready_in, .pin_in, .pin_oe_out,
  .pin_sync_out, .power_off_in, .wake_out);

// [bench/mio_board.sv]
// board model: each pin level from the device, the bench or a pull-up
`timescale 1ns/1ps
module mio_board (
  input wire [116:0] drv_in,
  input wire [116:0] oe_in,
  input wire [93:0] pu_in,
  input wire [116:0] ext_val_in,
  input wire [116:0] ext_oe_in,
  output reg [116:0] lvl_out
);
  integer i;
  // a floating pin without an enabled pull-up shows the inverse of its current drv_in value
  always @*
  begin
    for (i = 0; i < 117; i = i + 1)
      if (oe_in[i])
        lvl_out[i] = drv_in[i];
      else if (ext_oe_in[i])
        lvl_out[i] = ext_val_in[i];
      else if (i > 22 && pu_in[i - 23])
        lvl_out[i] = 1'b1;
      else
        lvl_out[i] = ~drv_in[i];
  end
endmodule // mio_board

// [bench/testbench.sv]
// self-checking bench of the multiplexed io port bank
`timescale 1ns/1ps
`include "mio_consts.vh"
module testbench;
  localparam [1:0] ok = `MIO_RESP_OKAY;
  localparam [1:0] er = `MIO_RESP_SLVERR;
  localparam [17:0] cd = 18'h26888;
  localparam [5:0] st = 6'h35;
  localparam [5:0] ex = 6'h1F;
  reg clk_sys_in, rst_b_in, power_off_in, w, g;
  reg s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  reg s_axi_arvalid_in, s_axi_rready_in;
  reg [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  reg [31:0] s_axi_wdata_in;
  reg [3:0] s_axi_wstrb_in;
  reg [116:0] alt1_drive_in, alt1_oe_in, alt2_drive_in, alt2_oe_in;
  reg [116:0] ext_val, ext_oe;
  wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, irq_out;
  wire s_axi_arready_out, s_axi_rvalid_out, wake_out;
  wire ext_irq_group_low_pending_out, ext_irq_group_high_pending_out;
  wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
  wire [31:0] s_axi_rdata_out, misc_ctrl_out;
  wire [116:0] pin_in, pin_out, pin_oe_out, pin_sync_out;
  wire [93:0] pullup_en_out;
  integer n_mismatch, cmp_count, j;
  mio_top i_dut (.clk_sys_in, .rst_b_in, .s_axi_awaddr_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
    .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
    .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
    .s_axi_rready_in, .pin_in, .pin_out, .pin_oe_out, .pullup_en_out,
    .alt1_drive_in, .alt1_oe_in, .alt2_drive_in, .alt2_oe_in,
    .pin_sync_out, .misc_ctrl_out, .power_off_in, .wake_out, .irq_out,
    .ext_irq_group_low_pending_out, .ext_irq_group_high_pending_out);
  mio_board i_board (.drv_in(pin_out), .oe_in(pin_oe_out),
    .pu_in(pullup_en_out), .ext_val_in(ext_val), .ext_oe_in(ext_oe),
    .lvl_out(pin_in));
  always #25 clk_sys_in = ~clk_sys_in;
  //////////////////////////////////////////////////////////////////////
  task cmp_w(input [31:0] gv, input [31:0] ev);
  begin
    cmp_count = cmp_count + 1;
    if (gv !== ev)
    begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: got %h exp %h", $time, gv, ev);
    end
  end
  endtask
  task cmp_b(input gv, input ev);
  begin
    cmp_w({31'h0, gv}, {31'h0, ev});
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
  begin
    @(posedge clk_sys_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    do
    begin
      @(posedge clk_sys_in);
      if (s_axi_awready_out === 1'b1)
        s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out === 1'b1)
        s_axi_wvalid_in <= 1'b0;
    end
    while (s_axi_bvalid_out !== 1'b1);
    s_axi_bready_in <= 1'b1;
    @(posedge clk_sys_in);
    s_axi_bready_in <= 1'b0;
    cmp_w({30'h0, s_axi_bresp_out}, {30'h0, r});
  end
  endtask
  task rd(input [7:0] a, input [31:0] m, input [31:0] e, input [1:0] r);
  begin
    @(posedge clk_sys_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    do
    begin
      @(posedge clk_sys_in);
      if (s_axi_arready_out === 1'b1)
        s_axi_arvalid_in <= 1'b0;
    end
    while (s_axi_rvalid_out !== 1'b1);
    s_axi_rready_in <= 1'b1;
    @(posedge clk_sys_in);
    s_axi_rready_in <= 1'b0;
    cmp_w(s_axi_rdata_out & m, e);
    cmp_w({30'h0, s_axi_rresp_out}, {30'h0, r});
  end
  endtask
  task watch;
  begin
    w = 1'b0;
    g = 1'b0;
    repeat (12)
    begin
      @(posedge clk_sys_in);
      if (wake_out === 1'b1)
        w = 1'b1;
      if (ext_irq_group_low_pending_out === 1'b1)
        g = 1'b1;
    end
  end
  endtask
  //////////////////////////////////////////////////////////////////////
  task t_reset;
  begin
    rd(8'h00, 32'hFFFFFFFF, `MIO_FUNC_A_RST, ok);
    rd(8'h10, 32'hFFFFFFFF, 32'h00000000, ok);
    rd(8'h18, 32'hFFFFFFFF, 32'h00000000, ok);
    rd(`MIO_ADR_MASK, 32'hFFFFFFFF, {8'h0, `MIO_MASK_RST}, ok);
    rd(8'h08, 32'h0, 32'h0, er);
    rd(8'hC0, 32'h0, 32'h0, er);
    cmp_w({9'h0, pin_out[22:0]}, {9'h0, alt1_drive_in[22:0]});
  end
  endtask
  task t_pins;
  begin
    wr(8'h10, 32'h00000021, ok);
    wr(8'h14, 32'h00000001, ok);
    wr(8'h30, 32'hC0000000, ok);
    repeat (3) @(posedge clk_sys_in);
    cmp_b(pin_out[23], 1'b1);
    cmp_b(pin_oe_out[23], 1'b1);
    cmp_b(pin_oe_out[24], 1'b0);
    cmp_b(pin_out[25], alt1_drive_in[25]);
    cmp_b(pin_out[65], alt2_drive_in[65]);
    rd(8'h14, 32'h00000007, 32'h00000003, ok);
    wr(8'h70, 32'h00155555, ok);
    wr(8'h74, 32'hFFFFFFFF, ok);
    rd(8'h74, 32'hFFFFFFFF, 32'h000007FF, ok);
  end
  endtask
  task t_pull;
  begin
    wr(8'h18, 32'h00000002, ok);
    repeat (3) @(posedge clk_sys_in);
    cmp_b(pullup_en_out[1], 1'b0);
    cmp_b(pullup_en_out[0], 1'b1);
    cmp_b(pullup_en_out[2], 1'b1);
  end
  endtask
  task t_porta;
  begin
    wr(8'h00, 32'h00000000, ok);
    wr(8'h04, 32'h00000005, ok);
    repeat (3) @(posedge clk_sys_in);
    cmp_w({9'h0, pin_out[22:0]}, 32'h00000005);
  end
  endtask
  task t_misc;
  begin
    wr(`MIO_ADR_MISC, 32'hA5C30F96, ok);
    s_axi_wstrb_in <= 4'h1;
    wr(`MIO_ADR_MISC, 32'h0000003C, ok);
    s_axi_wstrb_in <= 4'hF;
    cmp_w(misc_ctrl_out, 32'hA5C30F3C);
  end
  endtask
  task t_irq;
  begin
    wr(8'h50, 32'h00000202, ok);
    wr(`MIO_ADR_MASK, 32'h00FFFFFE, ok);
    for (j = 0; j < 6; j = j + 1)
    begin
      @(posedge clk_sys_in);
      ext_val[82] <= st[j];
      wr(`MIO_ADR_TRIG0, {12'h0, 4'h4, 13'h0, cd[j * 3 +: 3]}, ok);
      repeat (6) @(posedge clk_sys_in);
      wr(`MIO_ADR_PEND, 32'h00000001, ok);
      ext_val[82] <= ~st[j];
      repeat (8) @(posedge clk_sys_in);
      rd(`MIO_ADR_PEND, 32'h1, {31'h0, ex[j]}, ok);
      cmp_b(irq_out, ex[j]);
    end
  end
  endtask
  task t_wake;
  begin
    wr(8'h60, 32'h00020000, ok);
    wr(`MIO_ADR_TRIG2, 32'h00000004, ok);
    wr(`MIO_ADR_MASK, 32'h00FFFFFF, ok);
    power_off_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    ext_val[98] <= 1'b1;
    watch;
    cmp_b(w, 1'b0);
    ext_val[86] <= 1'b1;
    watch;
    cmp_b(w, 1'b1);
    cmp_b(g, 1'b0);
    power_off_in <= 1'b0;
    rd(8'h50, 32'hFFFFFFFF, 32'h00000202, ok);
  end
  endtask
  task t_filt;
  begin
    wr(`MIO_ADR_FILT, 32'h00000401, ok);
    wr(`MIO_ADR_PEND, 32'h00010000, ok);
    ext_val[98] <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    ext_val[98] <= 1'b1;
    repeat (10) @(posedge clk_sys_in);
    rd(`MIO_ADR_PEND, 32'h00010000, 32'h00000000, ok);
    ext_val[98] <= 1'b0;
    repeat (10) @(posedge clk_sys_in);
    ext_val[98] <= 1'b1;
    repeat (10) @(posedge clk_sys_in);
    rd(`MIO_ADR_PEND, 32'h00010000, 32'h00010000, ok);
    wr(`MIO_ADR_MASK, 32'h00FEFFFF, ok);
    cmp_b(ext_irq_group_high_pending_out, 1'b1);
    cmp_b(ext_irq_group_low_pending_out, 1'b0);
    cmp_b(irq_out, 1'b1);
  end
  endtask
  initial
  begin
    clk_sys_in = 1'b0;
    rst_b_in = 1'b0;
    power_off_in = 1'b0;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
    {s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
    s_axi_awaddr_in = 8'h00;
    s_axi_araddr_in = 8'h00;
    s_axi_wdata_in = 32'h00000000;
    s_axi_wstrb_in = 4'hF;
    alt1_drive_in = {39{3'h2}};
    alt2_drive_in = ~alt1_drive_in;
    alt1_oe_in = {94'h0, 23'h7FFFFF};
    alt2_oe_in = ~alt1_oe_in;
    ext_val = 117'h0;
    ext_val[24] = 1'b1;
    ext_oe = 117'h0;
    ext_oe[24] = 1'b1;
    ext_oe[82] = 1'b1;
    ext_oe[86] = 1'b1;
    ext_oe[98] = 1'b1;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    t_reset;
    t_pins;
    t_pull;
    t_porta;
    t_misc;
    t_irq;
    t_wake;
    t_filt;
    end_sim;
  end
  initial
  begin
    #200000;
    n_mismatch = n_mismatch + 1;
    end_sim;
  end
endmodule // testbench
